// ===== core/pss_mem.sv
// memory end: registered inputs, pipelined read data, byte-lane writes, burst sequencing
`timescale 1ns/1ps
// What this block does
// RULE_01: register all control inputs on rising edge; output_enable_n here gates the data drivers asynchronously
// RULE_02: read data leaves through output registers
// RULE_03: deasserted qualifier freezes the whole pipeline
// RULE_04: write only lanes whose selects are low
// RULE_05: select needs both lows low, high high
// RULE_06: release data drivers during write data phase
// RULE_07: new command every qualified cycle, no gaps
// RULE_08: burst addresses linear or interleaved by input
// RULE_09: array depth follows chosen word width; here depth is set by MODEL_ADDR_BITS alone
// RULE_10: data two qualified edges after command
module pss_mem
   import pss_pkg::*;
#(
   parameter int LANES = DEF_LANES,
   parameter int MODEL_ADDR_BITS = DEF_MODEL_ADDR_BITS
) (
   input wire logic clk,
   input wire logic reset,
   pss_if.mem bus
);
   localparam int WIDTH = LANES * LANE_BITS;
   localparam int DEPTH = 1 << MODEL_ADDR_BITS;

   typedef struct packed {
      pss_op_t op1;
      logic [MODEL_ADDR_BITS-1:0] addr1;
      logic [LANES-1:0] lanes_n1;
      pss_op_t op2;
      logic [MODEL_ADDR_BITS-1:0] addr2;
      logic [LANES-1:0] lanes_n2;
      logic [MODEL_ADDR_BITS-1:0] base;
      logic [BURST_BITS-1:0] count;
      logic last_write;
      logic [WIDTH-1:0] rdata;
      logic drive;
   } pss_mem_state_t;

   pss_mem_state_t s;
   pss_mem_state_t next_s;
   logic [WIDTH-1:0] mem [DEPTH];
   logic selected;
   logic [MODEL_ADDR_BITS-1:0] burst_addr;
   logic [BURST_BITS-1:0] next_count;
   logic do_write;

   // burst offset from the start address in either order
   function automatic logic [BURST_BITS-1:0] burst_offset(
      input logic [BURST_BITS-1:0] start,
      input logic [BURST_BITS-1:0] cnt,
      input logic order
   );
      if (order == BURST_INTERLEAVED) begin
         burst_offset = start ^ cnt;
      end else begin
         burst_offset = BURST_BITS'(start + cnt);
      end
   endfunction

   // lane-wise merge of new write data into a stored word
   function automatic logic [WIDTH-1:0] lane_merge(
      input logic [WIDTH-1:0] old_word,
      input logic [WIDTH-1:0] new_word,
      input logic [LANES-1:0] lanes_n
   );
      lane_merge = old_word;
      for (int i = 0; i < LANES; i++) begin
         if (!lanes_n[i]) begin
            lane_merge[i*LANE_BITS +: LANE_BITS] = new_word[i*LANE_BITS +: LANE_BITS];
         end
      end
   endfunction

   // RULE_05: three-way select
   assign selected = !bus.chip_select_low_first_n && bus.chip_select_high && !bus.chip_select_low_second_n;
   assign next_count = BURST_BITS'(s.count + 1'b1);
   // RULE_08: burst address sequence
   assign burst_addr = {s.base[MODEL_ADDR_BITS-1:BURST_BITS],
                        burst_offset(s.base[BURST_BITS-1:0], next_count, bus.burst_order)};
   assign do_write = !bus.clock_qualifier_n && s.op2 == PSS_OP_WRITE;

   always_comb begin
      next_s = s;
      // RULE_03: hold everything when not qualified
      if (!bus.clock_qualifier_n) begin
         // RULE_01: capture command on this edge
         // RULE_07: every qualified cycle takes a command
         if (!bus.adv_load_n) begin
            next_s.addr1 = bus.addr[MODEL_ADDR_BITS-1:0];
            next_s.base = bus.addr[MODEL_ADDR_BITS-1:0];
            next_s.count = '0;
            next_s.lanes_n1 = bus.byte_lane_write_select_n;
            if (!selected) begin
               next_s.op1 = PSS_OP_IDLE;
            end else if (!bus.write_n) begin
               next_s.op1 = PSS_OP_WRITE;
            end else begin
               next_s.op1 = PSS_OP_READ;
            end
            next_s.last_write = selected && !bus.write_n;
         end else begin
            // continuation keeps the direction of the burst opener
            next_s.addr1 = burst_addr;
            next_s.count = next_count;
            next_s.lanes_n1 = bus.byte_lane_write_select_n;
            next_s.op1 = (s.op1 == PSS_OP_IDLE && s.op2 == PSS_OP_IDLE) ? PSS_OP_IDLE
                       : (s.last_write ? PSS_OP_WRITE : PSS_OP_READ);
         end
         // RULE_10: second pipeline stage
         next_s.op2 = s.op1;
         next_s.addr2 = s.addr1;
         next_s.lanes_n2 = s.lanes_n1;
         // RULE_02: registered read data
         // a write landing on this same edge would be missed by the array read, so forward it
         if (s.op1 == PSS_OP_READ) begin
            next_s.rdata = (do_write && s.addr2 == s.addr1) ? lane_merge(mem[s.addr1], bus.dq, s.lanes_n2)
                         : mem[s.addr1];
         end
         // RULE_06: drive only for read data phases
         next_s.drive = s.op1 == PSS_OP_READ;
      end
      if (reset) begin
         next_s = '0;
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   // RULE_04: byte-lane write in the write data phase
   // RULE_09: array sized by lane count and depth
   always_ff @(posedge clk) begin
      if (do_write && !reset) begin
         mem[s.addr2] <= lane_merge(mem[s.addr2], bus.dq, s.lanes_n2);
      end
   end

   assign bus.mem_dq_out = s.rdata;
   // asynchronous output enable gates the registered drive
   assign bus.mem_dq_oe = s.drive && !bus.output_enable_n;
endmodule

// ===== include/pss_pkg.sv
// shared constants and types for the pipelined synchronous memory port
package pss_pkg;
   // word width choices: 36, 18 or 72 bits, nine bits per byte lane
   localparam int LANE_BITS = 9;
   localparam int DEF_LANES = 4;
   localparam int DEF_ADDR_BITS = 20;
   // read data and write data both follow the command by this many qualified edges
   localparam int PIPE_DEPTH = 2;
   localparam int BURST_BITS = 2;
   // burst order selector levels
   localparam logic BURST_LINEAR = 1'b0;
   localparam logic BURST_INTERLEAVED = 1'b1;
   // simulation model depth; the full array is far too large to elaborate by default
   localparam int DEF_MODEL_ADDR_BITS = 10;
   typedef enum logic [1:0] {
      PSS_OP_IDLE,
      PSS_OP_READ,
      PSS_OP_WRITE,
      PSS_OP_BURST
   } pss_op_t;
endpackage

// ===== include/pss_if.sv
// link between the memory controller and the memory
`timescale 1ns/1ps
interface pss_if
   import pss_pkg::*;
#(
   parameter int LANES = DEF_LANES,
   parameter int ADDR_BITS = DEF_ADDR_BITS
) (
   input wire logic clk
);
   logic [ADDR_BITS-1:0] addr;
   logic adv_load_n;
   logic write_n;
   logic [LANES-1:0] byte_lane_write_select_n;
   logic clock_qualifier_n;
   logic chip_select_low_first_n;
   logic chip_select_high;
   logic chip_select_low_second_n;
   logic output_enable_n;
   logic burst_order;
   logic [LANES*LANE_BITS-1:0] ctl_dq_out;
   logic ctl_dq_oe;
   logic [LANES*LANE_BITS-1:0] mem_dq_out;
   logic mem_dq_oe;
   // shared data bus resolved from the two enables; contention shows as a mix of both
   logic [LANES*LANE_BITS-1:0] dq;
   always_comb begin
      if (ctl_dq_oe && !mem_dq_oe) begin
         dq = ctl_dq_out;
      end else if (mem_dq_oe && !ctl_dq_oe) begin
         dq = mem_dq_out;
      end else begin
         dq = ctl_dq_out & mem_dq_out;
      end
   end
   modport ctl (
      output addr, adv_load_n, write_n, byte_lane_write_select_n, clock_qualifier_n,
      output chip_select_low_first_n, chip_select_high, chip_select_low_second_n,
      output output_enable_n, burst_order, ctl_dq_out, ctl_dq_oe,
      input dq
   );
   modport mem (
      input addr, adv_load_n, write_n, byte_lane_write_select_n, clock_qualifier_n,
      input chip_select_low_first_n, chip_select_high, chip_select_low_second_n,
      input output_enable_n, burst_order, dq,
      output mem_dq_out, mem_dq_oe
   );
endinterface

// ===== core/pss_ctl.sv
// controller end: issues commands, drives write data, collects read data
`timescale 1ns/1ps
module pss_ctl
   import pss_pkg::*;
#(
   parameter int LANES = DEF_LANES,
   parameter int ADDR_BITS = DEF_ADDR_BITS
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_burst,
   input wire logic [ADDR_BITS-1:0] req_addr,
   input wire logic [LANES-1:0] req_lanes,
   input wire logic [LANES*LANE_BITS-1:0] req_wdata,
   input wire logic hold,
   input wire logic interleaved,
   output logic [LANES*LANE_BITS-1:0] rd_data,
   output logic rd_valid,
   pss_if.ctl bus
);
   localparam int WIDTH = LANES * LANE_BITS;

   typedef struct packed {
      logic [ADDR_BITS-1:0] addr;
      logic adv_load_n;
      logic write_n;
      logic [LANES-1:0] lanes_n;
      logic qual_n;
      logic cs;
      logic burst_write;
      logic [1:0] rd_pipe;
      logic [1:0] wr_pipe;
      logic [WIDTH-1:0] wd1;
      logic [WIDTH-1:0] wd2;
      logic [WIDTH-1:0] wout;
      logic woe;
      logic [WIDTH-1:0] rd_data;
      logic rd_valid;
   } pss_ctl_state_t;

   pss_ctl_state_t s;
   pss_ctl_state_t next_s;
   logic issue_rd;
   logic issue_wr;

   always_comb begin
      next_s = s;
      issue_rd = 1'b0;
      issue_wr = 1'b0;
      next_s.rd_valid = 1'b0;
      // RULE_01: present inputs registered before the edge
      // RULE_03: hold suspends the memory from the next cycle for as long as it stays high
      next_s.qual_n = hold;
      if (!s.qual_n) begin
         // RULE_10: collect and drive two qualified edges after command
         next_s.rd_pipe = {s.rd_pipe[0], 1'b0};
         next_s.wr_pipe = {s.wr_pipe[0], 1'b0};
         next_s.wd2 = s.wd1;
         next_s.rd_valid = s.rd_pipe[1];
         next_s.rd_data = bus.dq;
      end
      if (!hold) begin
         // RULE_07: a new command every cycle
         if (req_valid) begin
            next_s.addr = req_addr;
            next_s.adv_load_n = req_burst;
            // RULE_04: write strobe and lane selects
            next_s.write_n = req_burst ? s.write_n : !req_write;
            next_s.lanes_n = ~req_lanes;
            // RULE_05: select the memory
            next_s.cs = 1'b1;
            issue_wr = req_burst ? s.burst_write : req_write;
            issue_rd = !issue_wr;
            next_s.burst_write = issue_wr;
         end else begin
            next_s.adv_load_n = 1'b0;
            next_s.cs = 1'b0;
            next_s.write_n = 1'b1;
            next_s.lanes_n = '1;
         end
         next_s.wd1 = req_wdata;
      end
      if (!s.qual_n) begin
         next_s.rd_pipe[0] = next_s.rd_pipe[0] | (s.cs && s.write_n == 1'b1);
         next_s.wr_pipe[0] = next_s.wr_pipe[0] | (s.cs && s.write_n == 1'b0);
         next_s.wd1 = s.qual_n ? s.wd1 : next_s.wd1;
         // write data launched for the second qualified edge after the command
         next_s.woe = s.wr_pipe[0];
         next_s.wout = s.wd2;
      end
      if (reset) begin
         next_s = '0;
         next_s.adv_load_n = 1'b0;
         next_s.write_n = 1'b1;
         next_s.lanes_n = '1;
         next_s.qual_n = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      s <= next_s;
   end

   assign bus.addr = s.addr;
   assign bus.adv_load_n = s.adv_load_n;
   assign bus.write_n = s.write_n;
   assign bus.byte_lane_write_select_n = s.lanes_n;
   assign bus.clock_qualifier_n = s.qual_n;
   assign bus.chip_select_low_first_n = !s.cs;
   assign bus.chip_select_high = s.cs;
   assign bus.chip_select_low_second_n = !s.cs;
   assign bus.output_enable_n = 1'b0;
   // RULE_08: static burst order strap
   assign bus.burst_order = interleaved;
   assign bus.ctl_dq_out = s.wout;
   assign bus.ctl_dq_oe = s.woe;
   assign rd_data = s.rd_data;
   assign rd_valid = s.rd_valid;
endmodule

// ===== tb/pss_link_props.sv
// assertions on the link between controller and memory
`timescale 1ns/1ps
module pss_link_props
   import pss_pkg::*;
#(
   parameter int LANES = DEF_LANES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic adv_load_n,
   input wire logic write_n,
   input wire logic clock_qualifier_n,
   input wire logic chip_select_low_first_n,
   input wire logic chip_select_high,
   input wire logic chip_select_low_second_n,
   input wire logic output_enable_n,
   input wire logic ctl_dq_oe,
   input wire logic mem_dq_oe,
   input wire logic [LANES*LANE_BITS-1:0] mem_dq_out
);
   logic sel;
   assign sel = !chip_select_low_first_n && chip_select_high && !chip_select_low_second_n;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence rd_cmd;
      sel && !adv_load_n && write_n && !clock_qualifier_n;
   endsequence
   sequence wr_cmd;
      sel && !adv_load_n && !write_n && !clock_qualifier_n;
   endsequence
   sequence idle_cmd;
      !sel && !adv_load_n && !clock_qualifier_n;
   endsequence
   rd_data_a: assert property (rd_cmd ##1 !clock_qualifier_n |=> mem_dq_oe && !ctl_dq_oe)
      else $error("read data not driven by memory");
   wr_data_a: assert property (wr_cmd ##1 !clock_qualifier_n |=> ctl_dq_oe && !mem_dq_oe)
      else $error("write data phase wrong");
   idle_cmd_a: assert property (idle_cmd ##1 !clock_qualifier_n |=> !mem_dq_oe && !ctl_dq_oe)
      else $error("unselected cycle moved data");
   freeze_out_a: assert property (clock_qualifier_n |=> $stable(mem_dq_oe) && $stable(mem_dq_out))
      else $error("memory output moved on ignored edge");
   no_contention_a: assert property (!(mem_dq_oe && ctl_dq_oe))
      else $error("both ends drive data");
   reset_idle_a: assert property (disable iff (1'b0) reset |=> clock_qualifier_n && !mem_dq_oe && !ctl_dq_oe)
      else $error("drivers active after reset");
   oe_gate_a: assert property (mem_dq_oe |-> !output_enable_n)
      else $error("memory drives with output enable off");
   turn_around_a: assert property (rd_cmd ##1 wr_cmd ##1 !clock_qualifier_n |=> ctl_dq_oe && $past(mem_dq_oe))
      else $error("read to write turnaround broken");
endmodule

// ===== tb/pipelined_sync_sram_port_bench.sv
// bench joining controller and memory ends over the link
`timescale 1ns/1ps
module pipelined_sync_sram_port_bench;
   import pss_pkg::*;
   typedef struct packed {logic w; logic b; logic [19:0] a; logic [3:0] l; logic [35:0] d;} pss_row_t;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic req_valid = 1'b0, req_write = 1'b0, req_burst = 1'b0, hold = 1'b0, interleaved = 1'b0;
   logic [19:0] req_addr = 20'h00000;
   logic [3:0] req_lanes = 4'h0;
   logic [35:0] req_wdata = 36'h000000000;
   logic [35:0] rd_data;
   logic rd_valid;
   logic [35:0] got[$];
   logic [35:0] exp_q[$];
   int n_fail = 0;
   int compares = 0;
   pss_row_t rows[14] = '{
      '{1'b1, 1'b0, 20'h00001, 4'hF, 36'h000000000}, '{1'b1, 1'b0, 20'h00002, 4'hF, 36'h123456789},
      '{1'b0, 1'b0, 20'h00001, 4'hF, 36'h000000000}, '{1'b1, 1'b0, 20'h00001, 4'h5, 36'hFFFFFFFFF},
      '{1'b0, 1'b0, 20'h00001, 4'hF, 36'h007FC01FF}, '{1'b0, 1'b0, 20'h00002, 4'hF, 36'h123456789},
      '{1'b1, 1'b0, 20'h00008, 4'hF, 36'h000000A01}, '{1'b1, 1'b1, 20'h00000, 4'hF, 36'h000000A02},
      '{1'b1, 1'b1, 20'h00000, 4'hF, 36'h000000A03}, '{1'b1, 1'b1, 20'h00000, 4'hF, 36'h000000A04},
      '{1'b0, 1'b0, 20'h00009, 4'hF, 36'h000000A02}, '{1'b0, 1'b1, 20'h00000, 4'hF, 36'h000000A03},
      '{1'b0, 1'b1, 20'h00000, 4'hF, 36'h000000A04}, '{1'b0, 1'b1, 20'h00000, 4'hF, 36'h000000A01}};
   pss_if link (.clk(clk));
   pss_ctl pss_ctl_inst (.clk(clk), .reset(reset), .req_valid(req_valid), .req_write(req_write),
      .req_burst(req_burst), .req_addr(req_addr), .req_lanes(req_lanes), .req_wdata(req_wdata), .hold(hold),
      .interleaved(interleaved), .rd_data(rd_data), .rd_valid(rd_valid), .bus(link));
   pss_mem pss_mem_inst (.clk(clk), .reset(reset), .bus(link));
   pss_link_props pss_link_props_inst (.clk(clk), .reset(reset), .adv_load_n(link.adv_load_n),
      .write_n(link.write_n), .clock_qualifier_n(link.clock_qualifier_n),
      .chip_select_low_first_n(link.chip_select_low_first_n), .chip_select_high(link.chip_select_high),
      .chip_select_low_second_n(link.chip_select_low_second_n), .output_enable_n(link.output_enable_n),
      .ctl_dq_oe(link.ctl_dq_oe), .mem_dq_oe(link.mem_dq_oe), .mem_dq_out(link.mem_dq_out));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      if (rd_valid === 1'b1) got.push_back(rd_data);
   end
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic put(input pss_row_t r);
      req_valid <= 1'b1;
      req_write <= r.w;
      req_burst <= r.b;
      req_addr <= r.a;
      req_lanes <= r.l;
      req_wdata <= r.d;
      if (!r.w) exp_q.push_back(r.d);
      @(posedge clk);
   endtask
   task automatic drain();
      req_valid <= 1'b0;
      repeat (12) @(posedge clk);
      check(36'(got.size()), 36'(exp_q.size()));
      foreach (exp_q[i]) check(got[i], exp_q[i]);
      got.delete();
      exp_q.delete();
   endtask
   task automatic final_report();
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      final_report();
   end
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) put(rows[i]);
      drain();
      // suspended edges must not lose the read in flight
      put(rows[5]);
      req_valid <= 1'b0;
      hold <= 1'b1;
      repeat (2) @(posedge clk);
      check(36'(link.clock_qualifier_n), 36'h000000001);
      repeat (3) @(posedge clk);
      hold <= 1'b0;
      drain();
      // mid-run reset keeps the array, then interleaved burst 9,8,11,10
      reset <= 1'b1;
      interleaved <= 1'b1;
      repeat (5) @(posedge clk);
      check(36'(link.mem_dq_oe), 36'h000000000);
      check(36'(rd_valid), 36'h000000000);
      reset <= 1'b0;
      @(posedge clk);
      put(rows[10]);
      put('{1'b0, 1'b1, 20'h00000, 4'hF, 36'h000000A01});
      put('{1'b0, 1'b1, 20'h00000, 4'hF, 36'h000000A04});
      put('{1'b0, 1'b1, 20'h00000, 4'hF, 36'h000000A03});
      drain();
      final_report();
   end
endmodule
